// file: logic/bmss_pkg.sv
// constants shared by the binary multi-speed select block
// assumes an APB master with 32-bit data and word-aligned registers
package bmss_pkg;
  localparam int NUM_TERM = 8;
  localparam int NUM_PRESET = 16;
  localparam int IDX_W = 4;
  localparam int FREQ_W = 16;
  localparam int ADDR_W = 8;

  // byte offsets
  localparam logic [ADDR_W-1:0] OFS_METHOD = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_TERM_LO = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_TERM_HI = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_MAX_FREQ = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_EDIT_VAL = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_EDIT_IDX = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_STORE = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_TARGET = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_PRESET_RD = 8'h24;

  // speed-select method field
  localparam logic [1:0] METHOD_BINARY = 2'h0;
  localparam logic [1:0] METHOD_RST = 2'h0;

  // terminal function codes, one byte per terminal
  localparam int FUNC_W = 8;
  localparam logic [FUNC_W-1:0] FUNC_SEL_BIT0 = 8'h02;
  localparam logic [FUNC_W-1:0] FUNC_NONE = 8'h00;

  // 50 Hz in 0.01 Hz units
  localparam logic [FREQ_W-1:0] MAX_FREQ_RST = 16'h1388;

  // status fields
  localparam int ST_IDX_LSB = 0;
  localparam int ST_BINARY = 4;
  localparam int ST_CLAMP = 5;
  localparam int ST_BUSY = 6;
  localparam int ST_TERM_LSB = 8;

  typedef enum logic [0:0] {
    ST_INIT = 1'b0,
    ST_RUN = 1'b1
  } bmss_state_t;
endpackage : bmss_pkg

// file: logic/bmss_sync.sv
// two-flop synchroniser for a group of asynchronous levels
// assumes each bit is an independent level; no bus coherency implied
`timescale 1ns/1ps
`default_nettype none
module bmss_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async,
  output logic [WIDTH-1:0] synced
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= async;
      sync_q <= meta_q;
    end
  end

  assign synced = sync_q;
endmodule : bmss_sync
`default_nettype wire

// file: logic/bmss_preset_mem.sv
// preset store: one write port, two registered read ports
// assumes the owner clears it after reset; contents have no reset
`timescale 1ns/1ps
`default_nettype none
module bmss_preset_mem #(
  parameter int DEPTH = 16,
  parameter int WIDTH = 16,
  parameter int AW = 4
) (
  input wire logic clk,
  input wire logic wrEn,
  input wire logic [AW-1:0] wrAddr,
  input wire logic [WIDTH-1:0] wrData,
  input wire logic [AW-1:0] rdAddrA,
  output logic [WIDTH-1:0] rdDataA,
  input wire logic [AW-1:0] rdAddrB,
  output logic [WIDTH-1:0] rdDataB
);
  if (DEPTH > (1 << AW)) begin : g_bad_depth
    $error("bmss_preset_mem: DEPTH exceeds AW");
  end

  logic [WIDTH-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      mem[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    rdDataA <= mem[rdAddrA];
    rdDataB <= mem[rdAddrB];
  end
endmodule : bmss_preset_mem
`default_nettype wire

// file: logic/bmss_top.sv
// binary multi-speed select: terminals to preset index to target frequency
// assumes an APB master on clk; terminals are asynchronous switch levels
`timescale 1ns/1ps
`default_nettype none
module bmss_top
  import bmss_pkg::*;
#(
  parameter int NTERM = NUM_TERM,
  parameter int NPRESET = NUM_PRESET
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [NTERM-1:0] termIn,
  output logic [FREQ_W-1:0] outputFrequencySetting,
  output logic [IDX_W-1:0] speedIndex,
  output logic targetClamped
);
  if (NTERM != NUM_TERM) begin : g_bad_nterm
    $error("bmss_top: NTERM must be 8");
  end
  if (NPRESET != NUM_PRESET) begin : g_bad_npreset
    $error("bmss_top: NPRESET must be 16");
  end
  if ((1 << IDX_W) != NUM_PRESET) begin : g_bad_idx
    $error("bmss_top: IDX_W must address every preset");
  end
  if (FREQ_W > 32) begin : g_bad_freq
    $error("bmss_top: FREQ_W must fit one data word");
  end
  if (NUM_TERM * FUNC_W != 64) begin : g_bad_term
    $error("bmss_top: terminal codes must fill two words");
  end
  if (ST_TERM_LSB + NUM_TERM > 32) begin : g_bad_status
    $error("bmss_top: status word too narrow for the terminals");
  end
  // two function-code words, terminals 0..3 then 4..7
  localparam int TERM_PER_WORD = 32 / FUNC_W;

  // register state
  logic [1:0] speedSelectMethod_q;
  logic [FUNC_W-1:0] termFunc_q [NUM_TERM];
  logic [FREQ_W-1:0] maxFrequencyLimit_q;
  logic [FREQ_W-1:0] editValue_q;
  logic [IDX_W-1:0] editIndex_q;
  logic storePulse_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  // datapath state
  bmss_state_t state_q;
  logic [IDX_W-1:0] initIdx_q;
  logic [IDX_W-1:0] selIndex_q;
  logic [FREQ_W-1:0] target_q;
  logic clamp_q;
  logic readValid_q;

  logic [NUM_TERM-1:0] termSync;
  logic [FREQ_W-1:0] presetSel;
  logic [FREQ_W-1:0] presetEdit;
  logic [IDX_W-1:0] selBits;
  logic binaryMode;
  logic setupPhase;
  logic wrAccess;
  logic storeReq;
  logic memWrEn;
  logic [IDX_W-1:0] memWrAddr;
  logic [FREQ_W-1:0] memWrData;

  bmss_sync #(
    .WIDTH(NUM_TERM)
  ) u_sync (
    .clk(clk),
    .reset(reset),
    .async(termIn),
    .synced(termSync)
  );

  bmss_preset_mem #(
    .DEPTH(NUM_PRESET),
    .WIDTH(FREQ_W),
    .AW(IDX_W)
  ) u_mem (
    .clk(clk),
    .wrEn(memWrEn),
    .wrAddr(memWrAddr),
    .wrData(memWrData),
    .rdAddrA(selIndex_q),
    .rdDataA(presetSel),
    .rdAddrB(editIndex_q),
    .rdDataB(presetEdit)
  );

  // is terminal t assigned to select bit b
  function automatic logic funcIsBit(input logic [FUNC_W-1:0] code,
                                     input int b);
    funcIsBit = (code == FUNC_SEL_BIT0 + FUNC_W'(b));
  endfunction : funcIsBit

  function automatic logic [FREQ_W-1:0] minFreq(
      input logic [FREQ_W-1:0] a, input logic [FREQ_W-1:0] b);
    minFreq = (a > b) ? b : a;
  endfunction : minFreq

  assign binaryMode = (speedSelectMethod_q == METHOD_BINARY);

  // terminal on gives one, unassigned bit stays zero
  always_comb begin
    selBits = '0;
    for (int b = 0; b < IDX_W; b++) begin
      for (int t = 0; t < NUM_TERM; t++) begin
        if (funcIsBit(termFunc_q[t], b) && termSync[t]) begin
          selBits[b] = 1'b1;
        end
      end
    end
  end

  // index follows the inputs every cycle in binary mode, zero otherwise, no command needed
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      selIndex_q <= '0;
    end else if (binaryMode) begin
      selIndex_q <= selBits;
    end else begin
      selIndex_q <= '0;
    end
  end
  // (unassigned bits never set in selBits)
  // (no hold on selIndex_q)

  // target is clamped to the limit, never above it
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      target_q <= '0;
      clamp_q <= 1'b0;
    end else if (readValid_q) begin
      target_q <= minFreq(presetSel, maxFrequencyLimit_q);
      clamp_q <= (presetSel > maxFrequencyLimit_q);
    end else begin
      target_q <= '0;
      clamp_q <= 1'b0;
    end
  end

  // the read launched on the last clear edge may still see the old word
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readValid_q <= 1'b0;
    end else begin
      readValid_q <= (state_q == ST_RUN);
    end
  end

  // clear the presets after reset so no unknown value reaches the target
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_INIT;
      initIdx_q <= '0;
    end else begin
      unique case (state_q)
        ST_INIT: begin
          initIdx_q <= initIdx_q + 1'b1;
          if (initIdx_q == IDX_W'(NUM_PRESET - 1)) begin
            state_q <= ST_RUN;
          end
        end
        ST_RUN: begin
          state_q <= ST_RUN;
        end
      endcase
    end
  end

  // stores during the clear are dropped
  always_comb begin
    if (state_q == ST_INIT) begin
      memWrEn = 1'b1;
      memWrAddr = initIdx_q;
      memWrData = '0;
    end else begin
      memWrEn = storePulse_q;
      memWrAddr = editIndex_q;
      memWrData = editValue_q;
    end
  end

  // APB: read data latched in setup, one access cycle, no wait states
  assign setupPhase = psel && !penable;
  assign wrAccess = psel && penable && pready_q && pwrite && !pslverr_q;
  // software must retry a store refused while busy
  assign storeReq = wrAccess && (paddr == OFS_STORE) && pwdata[0]
                    && (state_q == ST_RUN);

  function automatic logic addrMapped(input logic [ADDR_W-1:0] a);
    unique case (a)
      OFS_METHOD, OFS_TERM_LO, OFS_TERM_HI, OFS_MAX_FREQ, OFS_EDIT_VAL,
      OFS_EDIT_IDX, OFS_STORE, OFS_STATUS, OFS_TARGET,
      OFS_PRESET_RD: addrMapped = 1'b1;
      default: addrMapped = 1'b0;
    endcase
  endfunction : addrMapped

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      // error decided at setup so the access cycle needs no decode
      pready_q <= setupPhase;
      pslverr_q <= setupPhase && !addrMapped(paddr);
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      prdata_q <= '0;
    end else if (setupPhase && !pwrite) begin
      prdata_q <= '0;
      unique case (paddr)
        OFS_METHOD: prdata_q[1:0] <= speedSelectMethod_q;
        OFS_TERM_LO: prdata_q <= {termFunc_q[3], termFunc_q[2],
                                  termFunc_q[1], termFunc_q[0]};
        OFS_TERM_HI: prdata_q <= {termFunc_q[7], termFunc_q[6],
                                  termFunc_q[5], termFunc_q[4]};
        OFS_MAX_FREQ: prdata_q[FREQ_W-1:0] <= maxFrequencyLimit_q;
        OFS_EDIT_VAL: prdata_q[FREQ_W-1:0] <= editValue_q;
        OFS_EDIT_IDX: prdata_q[IDX_W-1:0] <= editIndex_q;
        OFS_STATUS: begin
          prdata_q[ST_IDX_LSB +: IDX_W] <= selIndex_q;
          prdata_q[ST_BINARY] <= binaryMode;
          prdata_q[ST_CLAMP] <= clamp_q;
          prdata_q[ST_BUSY] <= (state_q == ST_INIT);
          prdata_q[ST_TERM_LSB +: NUM_TERM] <= termSync;
        end
        OFS_TARGET: prdata_q[FREQ_W-1:0] <= target_q;
        OFS_PRESET_RD: prdata_q[FREQ_W-1:0] <= presetEdit;
        default: prdata_q <= '0;
      endcase
    end else begin
      // zero after every access cycle, back-to-back ones included
      prdata_q <= '0;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      speedSelectMethod_q <= METHOD_RST;
      maxFrequencyLimit_q <= MAX_FREQ_RST;
      editValue_q <= '0;
      editIndex_q <= '0;
    end else if (wrAccess) begin
      unique case (paddr)
        OFS_METHOD: speedSelectMethod_q <= pwdata[1:0];
        OFS_MAX_FREQ: maxFrequencyLimit_q <= pwdata[FREQ_W-1:0];
        OFS_EDIT_VAL: editValue_q <= pwdata[FREQ_W-1:0];
        OFS_EDIT_IDX: editIndex_q <= pwdata[IDX_W-1:0];
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      for (int t = 0; t < NUM_TERM; t++) begin
        termFunc_q[t] <= FUNC_NONE;
      end
    end else if (wrAccess && paddr == OFS_TERM_LO) begin
      for (int t = 0; t < TERM_PER_WORD; t++) begin
        termFunc_q[t] <= pwdata[t*FUNC_W +: FUNC_W];
      end
    end else if (wrAccess && paddr == OFS_TERM_HI) begin
      for (int t = 0; t < TERM_PER_WORD; t++) begin
        termFunc_q[t+TERM_PER_WORD] <= pwdata[t*FUNC_W +: FUNC_W];
      end
    end
  end

  // store is a one-shot, the edit buffer alone never reaches the memory
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      storePulse_q <= 1'b0;
    end else begin
      storePulse_q <= storeReq;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign outputFrequencySetting = target_q;
  assign speedIndex = selIndex_q;
  assign targetClamped = clamp_q;
endmodule : bmss_top
`default_nettype wire

// file: verif/bmss_props.sv
// checker on bmss_top ports: apb timing, read data, select index
// assumes bound onto bmss_top, one clock, async active-high reset
`timescale 1ns/1ps
`default_nettype none
module bmss_props
  import bmss_pkg::*;
#(
  parameter int NTERM = NUM_TERM
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [NTERM-1:0] termIn,
  input wire logic [FREQ_W-1:0] outputFrequencySetting,
  input wire logic [IDX_W-1:0] speedIndex,
  input wire logic targetClamped
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire logic isSetup = psel && !penable;
  wire logic isRead = isSetup && !pwrite;

  a_ready_after_setup:
    assert property (isSetup |=> pready && psel && penable)
    else $error("no pready after setup");
  a_ready_in_access:
    assert property (pready |-> psel && penable && $past(isSetup))
    else $error("pready outside access");
  a_idle_rdata_zero:
    assert property (!pready |-> prdata == 32'h0 && !pslverr)
    else $error("read data or error while idle");
  a_unmapped_err:
    assert property (isSetup && paddr > OFS_PRESET_RD |=> pslverr)
    else $error("unmapped access not refused");
  a_store_reads_zero:
    assert property (isRead && paddr == OFS_STORE |=> prdata == 32'h0)
    else $error("store register reads nonzero");
  a_status_index:
    assert property (isRead && paddr == OFS_STATUS |=>
      prdata[3:0] == $past(speedIndex) && prdata[5] == $past(targetClamped))
    else $error("status disagrees with index");
  a_target_read:
    assert property (isRead && paddr == OFS_TARGET |=>
      prdata == {16'h0, $past(outputFrequencySetting)})
    else $error("target read disagrees with output");
  a_index_holds:
    assert property ((!psel && $stable(termIn))[*5] |=> $stable(speedIndex))
    else $error("index moved without a cause");
  a_clamp_nonzero:
    assert property (targetClamped |-> outputFrequencySetting != 16'h0)
    else $error("clamped target is zero");
endmodule : bmss_props

bind bmss_top bmss_props #(.NTERM(NTERM)) u_props (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .termIn(termIn),
  .outputFrequencySetting(outputFrequencySetting), .speedIndex(speedIndex),
  .targetClamped(targetClamped));
`default_nettype wire

// file: verif/bmss_switch_model.sv
// terminal switches: on drives high, off drives low
// assumes nothing of the clock; levels settle off the clock grid
`timescale 1ns/1ps
`default_nettype none
module bmss_switch_model (
  input wire logic [7:0] want,
  output logic [7:0] termIn
);
  initial termIn = 8'h00;
  // odd delay so the synchroniser sees a truly async edge
  always @(want) termIn <= #37 want;
endmodule : bmss_switch_model
`default_nettype wire

// file: verif/binary_multi_speed_select_tb_top.sv
// bench for bmss_top: presets over apb, switches pick the target
// assumes bmss_top, bmss_props and bmss_switch_model compiled first
`timescale 1ns/1ps
`default_nettype none
module binary_multi_speed_select_tb_top
  import bmss_pkg::*;
;
  logic clk, reset, psel, penable, pwrite, pready, pslverr, targetClamped;
  logic [7:0] paddr, want, termIn;
  logic [31:0] pwdata, prdata, rd, seed;
  logic [15:0] outputFrequencySetting, pre[16], p, mx;
  logic [3:0] speedIndex, e;
  logic er;
  logic [31:0] loTab[5] = '{32'h05040302, 32'h0, 32'h0, 32'h00030002,
    32'h05040302};
  logic [31:0] hiTab[5] = '{32'h0, 32'h02030405, 32'h02030405, 32'h0, 32'h0};
  int numErrors = 0, totalChecks = 0, cyc = 0;

  bmss_top u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .termIn(termIn),
    .outputFrequencySetting(outputFrequencySetting),
    .speedIndex(speedIndex), .targetClamped(targetClamped));
  bmss_switch_model u_sw (.want(want), .termIn(termIn));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task finishTest;
    $display("checks %0d errors %0d", totalChecks, numErrors);
    if (numErrors == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : finishTest

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      finishTest;
    end
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      numErrors++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // answer taken at the same rising edge that samples pready high
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  function automatic logic [3:0] expIdx(input logic [7:0] t,
      input logic [63:0] codes, input logic bin);
    logic [3:0] r;
    logic [7:0] c;
    r = 4'h0;
    for (int i = 0; i < 8; i++) begin
      c = codes[8*i+:8];
      if (c >= 8'h02 && c <= 8'h05) r[c[1:0]-2'h2] |= t[i];
    end
    return bin ? r : 4'h0;
  endfunction : expIdx

  initial begin
    seed = 32'h8CFC99B3;
    {psel, penable, pwrite, paddr, pwdata, want} = '0;
    reset = 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    apb(1'b0, OFS_METHOD, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, OFS_MAX_FREQ, 32'h0);
    chk(rd, 32'h1388);
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(er), 32'h1);
    apb(1'b0, OFS_STORE, 32'h0);
    chk(rd, 32'h0);
    for (int i = 0; i < 16; i++) begin
      pre[i] = (i == 15) ? 16'h2000 : 16'($random(seed)) & 16'h1FFF;
      apb(1'b1, OFS_EDIT_IDX, i);
      apb(1'b1, OFS_EDIT_VAL, 32'(pre[i]));
      apb(1'b1, OFS_STORE, 32'h1);
    end
    apb(1'b1, OFS_EDIT_VAL, 32'h0ABC);
    repeat (2) @(posedge clk);
    apb(1'b0, OFS_PRESET_RD, 32'h0);
    chk(rd, 32'(pre[15]));
    // table row 3 uses low bits only, row 4 leaves binary mode
    for (int m = 0; m < 5; m++) begin
      mx = (m == 2) ? 16'h2000 : 16'h1388;
      apb(1'b1, OFS_TERM_LO, loTab[m]);
      apb(1'b1, OFS_TERM_HI, hiTab[m]);
      apb(1'b1, OFS_MAX_FREQ, 32'(mx));
      apb(1'b1, OFS_METHOD, (m == 4) ? 32'h1 : 32'h0);
      for (int k = 0; k < 12; k++) begin
        @(posedge clk);
        want <= (k < 2) ? {8{k[0]}} : 8'($random(seed));
        repeat (8) @(negedge clk);
        e = expIdx(want, {hiTab[m], loTab[m]}, m != 4);
        p = pre[e];
        chk(32'(speedIndex), 32'(e));
        chk(32'(outputFrequencySetting), 32'((p > mx) ? mx : p));
        chk(32'(targetClamped), 32'(p > mx));
        apb(1'b0, OFS_STATUS, 32'h0);
        chk(32'(rd[3:0]), 32'(e));
        chk(32'(rd[ST_BINARY]), 32'(m != 4));
        apb(1'b0, OFS_TARGET, 32'h0);
        chk(rd, 32'((p > mx) ? mx : p));
      end
    end
    finishTest;
  end
endmodule : binary_multi_speed_select_tb_top
`default_nettype wire
